// ### common/aerur_pkg.sv
package aerur_pkg;

    // dword offsets inside configuration space
    localparam logic [11:0] AERUR_OFS_HEADER = 12'h100;
    localparam logic [11:0] AERUR_OFS_FLAGS = 12'h104;
    localparam logic [11:0] AERUR_OFS_GATE = 12'h108;
    localparam logic [11:0] AERUR_OFS_SEVERITY = 12'h10C;
    localparam logic [11:0] AERUR_OFS_CORR_FLAGS = 12'h110;
    localparam logic [11:0] AERUR_OFS_CORR_GATE = 12'h114;
    localparam logic [11:0] AERUR_OFS_CAP_CTRL = 12'h118;
    localparam logic [11:0] AERUR_OFS_HDR_LOG = 12'h11C;

    // capability header fields
    localparam logic [15:0] AERUR_CAP_ID = 16'h0001;
    localparam int AERUR_ID_LSB = 0;
    localparam int AERUR_VER_LSB = 16;
    localparam int AERUR_NEXT_LSB = 20;
    localparam logic [3:0] AERUR_VER_DEFAULT = 4'h2;
    localparam logic [11:0] AERUR_NEXT_DEFAULT = 12'h140;

    // implemented flag and gate bits: 4 and 12..20
    localparam logic [31:0] AERUR_IMPL_MASK = 32'h001FF010;
    localparam logic [31:0] AERUR_FLAGS_RESET = 32'h00000000;
    localparam logic [31:0] AERUR_GATE_RESET = 32'h00000000;

    // one configuration access from the host bridge
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } aerur_cfg_req_t;

    // values caught from the nonvolatile store at initialisation
    typedef struct packed {
        logic valid;
        logic [3:0] version;
        logic serial_id_enable;
        logic [11:0] next_enabled;
    } aerur_nvm_t;

    // message request towards the transaction layer
    typedef struct packed {
        logic valid;
        logic fatal;
        logic [31:0] errors;
    } aerur_msg_t;

endpackage

// ### hdl/aerur_w1c_bank.sv
`timescale 1ns/1ps
module aerur_w1c_bank
    import aerur_pkg::*;
(
    // clock and fundamental reset
    input wire logic clk,
    input wire logic rst_n,
    // detection and software clear
    input wire logic [31:0] detect,
    input wire logic [31:0] clear,
    // held flags
    output logic [31:0] flags
);

    // the set wins over a clear in the same cycle so no event is lost
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags <= AERUR_FLAGS_RESET;
        end
        else
        begin
            flags <= ((flags & ~clear) | detect) & AERUR_IMPL_MASK;
        end
    end

endmodule

// ### hdl/aerur_regs.sv
`timescale 1ns/1ps

// Notes on behaviour
// - header bits 15:0 read 0x0001 as the capability identifier
// - header bits 19:16 read the version, default 0x2
// - version is loaded from the nonvolatile store at initialisation
// - header bits 31:20 point to next capability, default 0x140
// - serial identifier disabled: pointer takes next enabled capability offset
// - flags at 0x104, gate 0x108, severity 0x10C, others beyond
// - a flag sets on its error and holds until software clears it
// - writing one clears a flag; writing zero leaves it
// - flag bit 4 is sticky write-one-clear, reset zero
// - flag bits 12 and 13 are sticky write-one-clear, reset zero
// - flag bits 14 to 20 are sticky write-one-clear, reset zero
// - flag bit 5, bits 21-25 and reserved bits read zero
// - one gate bit per flag bit at the same position
// - a gated error sends no error message to the host bridge
// - gate bits 4 and 12-20 are sticky read-write, reset zero
// - gate bit 5, bits 21-25 and reserved bits stay zero
// - unmasked error is fatal when its severity bit is one
module aerur_regs
(
    // clock and resets
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic HOT_RESETN,
    // configuration access from the host bridge
    input wire aerur_pkg::aerur_cfg_req_t CFG_REQ,
    output logic CFG_ACK,
    output logic CFG_HIT,
    output logic [31:0] CFG_RDATA,
    // initialisation values from the nonvolatile store
    input wire aerur_pkg::aerur_nvm_t NVM,
    // error detection from link and transaction layers
    input wire logic [31:0] ERR_DETECT,
    // severity bits held by the severity register outside
    input wire logic [31:0] SEVERITY,
    // error message request
    output aerur_pkg::aerur_msg_t MSG,
    // live register values
    output logic [31:0] FLAGS,
    output logic [31:0] GATE
);
    import aerur_pkg::*;

    logic [3:0] version;
    logic [11:0] next_ptr;
    logic [31:0] gate;
    logic [31:0] flags;
    logic [31:0] clear;
    logic [31:0] detect;
    logic [31:0] wr_bits;
    logic [31:0] next_rdata;
    logic hit;
    logic wr_flags;
    logic wr_gate;
    logic [31:0] report;

    // expand byte enables to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    // compare a request address with a register dword offset
    function automatic logic addr_is(input logic [11:0] a,
                                     input logic [11:0] ofs);
        return a[11:2] == ofs[11:2];
    endfunction

    // decode; registers beyond 0x108 belong to neighbouring logic
    always_comb
    begin
        wr_bits = CFG_REQ.wdata & lane_mask(CFG_REQ.byte_en);
        wr_flags = CFG_REQ.valid && CFG_REQ.write
                   && addr_is(CFG_REQ.addr, AERUR_OFS_FLAGS);
        wr_gate = CFG_REQ.valid && CFG_REQ.write
                  && addr_is(CFG_REQ.addr, AERUR_OFS_GATE);
        hit = addr_is(CFG_REQ.addr, AERUR_OFS_HEADER)
              || addr_is(CFG_REQ.addr, AERUR_OFS_FLAGS)
              || addr_is(CFG_REQ.addr, AERUR_OFS_GATE);
    end

    // only ones written clear; zeros leave flags alone
    assign clear = wr_flags ? wr_bits : 32'h00000000;
    // detection is not gated so masked errors still log
    assign detect = ERR_DETECT & AERUR_IMPL_MASK;

    // sticky flags on the fundamental reset only
    aerur_w1c_bank u_flags
    (
        .clk(CLOCK),
        .rst_n(RESETN),
        .detect(detect),
        .clear(clear),
        .flags(flags)
    );

    // header values caught from the store, not hard wired
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            version <= AERUR_VER_DEFAULT;
            next_ptr <= AERUR_NEXT_DEFAULT;
        end
        else if (NVM.valid)
        begin
            version <= NVM.version;
            next_ptr <= NVM.serial_id_enable ? AERUR_NEXT_DEFAULT
                        : NVM.next_enabled;
        end
    end

    // gate bits, sticky read-write; unimplemented positions forced low
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            gate <= AERUR_GATE_RESET;
        end
        else if (wr_gate)
        begin
            gate <= ((gate & ~lane_mask(CFG_REQ.byte_en)) | wr_bits)
                    & AERUR_IMPL_MASK;
        end
    end

    // read mux
    always_comb
    begin
        next_rdata = 32'h00000000;
        if (addr_is(CFG_REQ.addr, AERUR_OFS_HEADER))
        begin
            next_rdata = {next_ptr, version, AERUR_CAP_ID};
        end
        else if (addr_is(CFG_REQ.addr, AERUR_OFS_FLAGS))
        begin
            next_rdata = flags;
        end
        else if (addr_is(CFG_REQ.addr, AERUR_OFS_GATE))
        begin
            next_rdata = gate;
        end
    end

    // access answer one cycle after the request; hot reset drops it
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            CFG_ACK <= 1'b0;
            CFG_HIT <= 1'b0;
            CFG_RDATA <= 32'h00000000;
        end
        else if (!HOT_RESETN)
        begin
            CFG_ACK <= 1'b0;
            CFG_HIT <= 1'b0;
            CFG_RDATA <= 32'h00000000;
        end
        else
        begin
            CFG_ACK <= CFG_REQ.valid;
            CFG_HIT <= CFG_REQ.valid && hit;
            CFG_RDATA <= (CFG_REQ.valid && !CFG_REQ.write)
                         ? next_rdata : 32'h00000000;
        end
    end

    // errors worth a message: detected and not gated
    assign report = detect & ~gate;

    // message request, fatal if any reported error has severity set
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            MSG <= '0;
        end
        else if (!HOT_RESETN)
        begin
            MSG <= '0; // link is down, nothing to send
        end
        else
        begin
            MSG.valid <= |report;
            MSG.fatal <= |(report & SEVERITY);
            MSG.errors <= report;
        end
    end

    // registered copies for neighbouring logic
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            FLAGS <= 32'h00000000;
            GATE <= 32'h00000000;
        end
        else
        begin
            FLAGS <= flags;
            GATE <= gate;
        end
    end

    // a detected error shows in the flags on the next cycle
    a_flag_sets: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        detect[4] |=> flags[4])
        else $error("flag 4 did not set");

    // one written clears when no new event arrives
    a_w1c_clear: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (wr_flags && wr_bits[12] && !detect[12]) |=> !flags[12])
        else $error("write one did not clear flag");

    // without a clear or event a flag holds
    a_flag_hold: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (flags[15] && !clear[15]) |=> flags[15])
        else $error("flag dropped without clear");

    // an event and a clear together: the event must not be lost
    a_set_wins: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (clear[12] && detect[12]) |=> flags[12])
        else $error("clear beat a new event");

    // a gated error is still logged, only its message is held back
    a_gated_logs: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (detect[13] && gate[13]) |=> flags[13])
        else $error("gated error not logged");

    // unsupported and reserved flags never set
    a_flag_rsvd: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (flags & ~AERUR_IMPL_MASK) == 32'h00000000)
        else $error("unsupported flag bit set");

    // gate write takes effect for implemented bits only
    a_gate_write: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (wr_gate && CFG_REQ.byte_en[2]) |=>
        gate[20:16] == $past(wr_bits[20:16]))
        else $error("gate write lost");

    // reserved gate positions ignore writes
    a_gate_rsvd: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (gate & ~AERUR_IMPL_MASK) == 32'h00000000)
        else $error("unsupported gate bit set");

    // gated error gives no message
    a_gate_mutes: assert property (
        @(posedge CLOCK) disable iff (!RESETN || !HOT_RESETN)
        (ERR_DETECT == 32'h00000010 && gate[4]) |=> !MSG.valid)
        else $error("gated error produced a message");

    // fatal follows severity for a single ungated error
    a_fatal_sev: assert property (
        @(posedge CLOCK) disable iff (!RESETN || !HOT_RESETN)
        (ERR_DETECT == 32'h00002000 && !gate[13])
        |=> (MSG.valid && MSG.fatal == $past(SEVERITY[13])))
        else $error("message severity wrong");

    // read requests as the bank takes them
    sequence s_hdr_read;
        CFG_REQ.valid && !CFG_REQ.write
        && addr_is(CFG_REQ.addr, AERUR_OFS_HEADER);
    endsequence

    sequence s_flags_read;
        CFG_REQ.valid && !CFG_REQ.write
        && addr_is(CFG_REQ.addr, AERUR_OFS_FLAGS);
    endsequence

    sequence s_gate_read;
        CFG_REQ.valid && !CFG_REQ.write
        && addr_is(CFG_REQ.addr, AERUR_OFS_GATE);
    endsequence

    // header read returns identifier, version and pointer
    a_hdr_read: assert property (
        @(posedge CLOCK) disable iff (!RESETN || !HOT_RESETN)
        s_hdr_read |=> CFG_RDATA
        == {$past(next_ptr), $past(version), AERUR_CAP_ID})
        else $error("capability header wrong");

    // flags read back as they stood when the read was taken
    a_flags_read: assert property (
        @(posedge CLOCK) disable iff (!RESETN || !HOT_RESETN)
        s_flags_read |=> CFG_RDATA == $past(flags))
        else $error("flag read wrong");

    // gate read back bit for bit at the flag positions
    a_gate_read: assert property (
        @(posedge CLOCK) disable iff (!RESETN || !HOT_RESETN)
        s_gate_read |=> CFG_RDATA == $past(gate))
        else $error("gate read wrong");

    // every request outside hot reset is answered on the next edge
    a_ack_next: assert property (
        @(posedge CLOCK) disable iff (!RESETN || !HOT_RESETN)
        CFG_REQ.valid |=> (CFG_ACK && CFG_HIT == $past(hit)))
        else $error("access answer missing");

    // offsets outside the bank answer with no hit and zero data
    a_unmapped: assert property (
        @(posedge CLOCK) disable iff (!RESETN || !HOT_RESETN)
        (CFG_REQ.valid && !hit) |=> (!CFG_HIT && CFG_RDATA == 32'h00000000))
        else $error("unmapped access answered");

    // the link is down in hot reset, so nothing is sent
    a_hot_silent: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        !HOT_RESETN |=> (!CFG_ACK && !MSG.valid))
        else $error("output active in hot reset");

    // the store's version reaches the header on the next edge
    a_nvm_load: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        NVM.valid |=> version == $past(NVM.version))
        else $error("version not loaded");

    // a disabled serial identifier is skipped in the chain
    a_next_skip: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (NVM.valid && !NVM.serial_id_enable)
        |=> next_ptr == $past(NVM.next_enabled))
        else $error("pointer did not skip");

    // an enabled serial identifier keeps the default pointer
    a_next_keep: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (NVM.valid && NVM.serial_id_enable)
        |=> next_ptr == AERUR_NEXT_DEFAULT)
        else $error("default pointer lost");

    // hot reset leaves sticky bits untouched
    a_hot_keep: assert property (
        @(posedge CLOCK) disable iff (!RESETN)
        (!HOT_RESETN && !wr_flags && flags[16]) |=> flags[16])
        else $error("hot reset cleared sticky flag");

endmodule

// ### dv/aerur_host_model.sv
`timescale 1ns/1ps
module aerur_host_model
(
    // bus clock and answer
    input wire logic clk,
    input wire logic ack,
    input wire logic hit,
    input wire logic [31:0] rdata,
    // request towards the register bank
    output aerur_pkg::aerur_cfg_req_t req
);
    import aerur_pkg::*;

    initial req = '0;

    // one-cycle request off the falling edge, answer taken a cycle later
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [3:0] be, input logic [31:0] d, output logic [33:0] ans);
        @(negedge clk);
        req <= '{1'b1, w, a, be, d};
        @(negedge clk);
        // released fields turn over so a stale value never looks valid
        req <= '{1'b0, ~w, ~a, ~be, ~d};
        ans = {ack, hit, rdata};
    endtask
endmodule

// ### dv/pcie_aer_uncorrectable_regs_test.sv
`timescale 1ns/1ps
module pcie_aer_uncorrectable_regs_test;
    import aerur_pkg::*;

    // stimulus and observed values
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic hot_resetn = 1'b0;
    aerur_cfg_req_t cfg_req;
    aerur_nvm_t nvm = '0;
    aerur_msg_t msg;
    logic [31:0] err_detect = '0;
    logic [31:0] severity = '0;
    logic cfg_ack;
    logic cfg_hit;
    logic [31:0] cfg_rdata, flags, gate, exp_flags, exp_gate, exp_hdr;
    logic [31:0] d, r;
    logic [33:0] ans;
    int seed = 41108;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #2.5 clock = ~clock;

    aerur_regs DUT (.CLOCK(clock), .RESETN(resetn), .HOT_RESETN(hot_resetn),
        .CFG_REQ(cfg_req), .CFG_ACK(cfg_ack), .CFG_HIT(cfg_hit),
        .CFG_RDATA(cfg_rdata), .NVM(nvm), .ERR_DETECT(err_detect),
        .SEVERITY(severity), .MSG(msg), .FLAGS(flags), .GATE(gate));

    aerur_host_model host (.clk(clock), .ack(cfg_ack), .hit(cfg_hit),
        .rdata(cfg_rdata), .req(cfg_req));

    // lane mask from byte enables
    function automatic logic [31:0] bem(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // message expected one cycle after a detection
    function automatic logic [33:0] msg_of(input logic [31:0] det,
        input logic [31:0] g, input logic [31:0] sev);
        logic [31:0] rep;
        rep = det & AERUR_IMPL_MASK & ~g;
        return {|rep, |(rep & sev), rep};
    endfunction

    task automatic chk(input string nm, input logic [33:0] e,
        input logic [33:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic h,
        input logic [31:0] e);
        host.xfer(1'b0, a, 4'hF, 32'h0, ans);
        chk("read answer", {1'b1, h, e}, ans);
    endtask

    task automatic wr(input logic [11:0] a, input logic [3:0] be,
        input logic [31:0] v);
        host.xfer(1'b1, a, be, v, ans);
        chk("write answer", {1'b1, 1'b1, 32'h0}, ans);
    endtask

    task automatic check_all();
        rd(AERUR_OFS_HEADER, 1'b1, exp_hdr);
        rd(AERUR_OFS_FLAGS, 1'b1, exp_flags);
        rd(AERUR_OFS_GATE, 1'b1, exp_gate);
        chk("FLAGS", {2'b0, exp_flags}, {2'b0, flags});
        chk("GATE", {2'b0, exp_gate}, {2'b0, gate});
    endtask

    // one detection cycle; the message follows on the next edge
    task automatic det(input logic [31:0] dd, input logic [31:0] ss);
        @(negedge clock);
        err_detect <= dd;
        severity <= ss;
        @(negedge clock);
        chk("MSG", msg_of(dd, exp_gate, ss), msg);
        err_detect <= 32'h0;
        exp_flags = exp_flags | (dd & AERUR_IMPL_MASK);
    endtask

    // one initialisation load; the pointer skips a disabled serial id
    task automatic nv(input logic [3:0] v, input logic en,
        input logic [11:0] nx);
        @(negedge clock);
        nvm <= '{1'b1, v, en, nx};
        @(negedge clock);
        nvm <= '{1'b0, ~v, ~en, ~nx};
        exp_hdr = {(en ? AERUR_NEXT_DEFAULT : nx), v, AERUR_CAP_ID};
    endtask

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hang guard, well above the thirteen hundred or so cycles the run needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    // main sequence: reset values, loads, random traffic, resets
    initial
    begin
        repeat (3) @(posedge clock);
        @(negedge clock);
        resetn <= 1'b1;
        hot_resetn <= 1'b1;
        exp_flags = AERUR_FLAGS_RESET;
        exp_gate = AERUR_GATE_RESET;
        exp_hdr = 32'h14020001;
        check_all();
        nv(4'h3, 1'b0, 12'h1A0);
        check_all();
        nv(4'h2, 1'b1, 12'h1C0);
        for (int i = 0; i < 400; i++)
        begin
            d = $random(seed);
            r = $random(seed);
            case (i % 5)
                0:
                    det(d, r);
                1:
                begin
                    wr(AERUR_OFS_FLAGS, r[3:0], d | r);
                    exp_flags = exp_flags & ~((d | r) & bem(r[3:0]));
                end
                2:
                begin
                    wr(AERUR_OFS_GATE, r[3:0], d);
                    exp_gate = (exp_gate & ~bem(r[3:0]))
                        | (d & bem(r[3:0]) & AERUR_IMPL_MASK);
                end
                3:
                begin
                    wr(AERUR_OFS_HEADER, 4'hF, d);
                    rd(12'h10C + {2'b0, r[7:0], 2'b0}, 1'b0, 32'h0);
                end
                default:
                    check_all();
            endcase
        end
        // masked error still logs but sends nothing; severity picks fatal
        wr(AERUR_OFS_FLAGS, 4'hF, 32'hFFFFFFFF);
        exp_flags = 32'h00000000;
        wr(AERUR_OFS_GATE, 4'hF, 32'h00000010);
        exp_gate = 32'h00000010;
        det(32'h00000010, 32'h0);
        det(32'h00002000, 32'h00002000);
        det(32'h00002000, 32'h0);
        check_all();
        // detection and clear land on the same edge: detection wins
        fork
            wr(AERUR_OFS_FLAGS, 4'hF, 32'h00001000);
            begin
                @(negedge clock);
                err_detect <= 32'h00001000;
                @(negedge clock);
                err_detect <= 32'h0;
            end
        join
        exp_flags = exp_flags | 32'h00001000;
        check_all();
        // hot reset keeps every sticky bit and leaves requests unanswered
        @(negedge clock);
        hot_resetn <= 1'b0;
        host.xfer(1'b0, AERUR_OFS_FLAGS, 4'hF, 32'h0, ans);
        chk("hot answer", 34'h0, ans);
        hot_resetn <= 1'b1;
        check_all();
        // fundamental reset returns to defaults
        resetn <= 1'b0;
        repeat (3) @(negedge clock);
        resetn <= 1'b1;
        exp_flags = AERUR_FLAGS_RESET;
        exp_gate = AERUR_GATE_RESET;
        exp_hdr = 32'h14020001;
        check_all();
        end_of_test();
    end
endmodule
